// [verilog/ldc_bank.sv]
// Per-unit configuration register bank behind the index and data ports
`timescale 1ns/1ps
`default_nettype none
module ldc_bank
(
  // Clock and resets
  input wire logic mclk,
  input wire logic rst,
  input wire logic stby_rst,
  // Configuration port access
  input wire logic cfg_state,
  input wire logic index_wr,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic rd_valid,
  // Unit controls
  output logic [ldc_pkg::NUNITS-1:0] unit_active,
  output logic [ldc_pkg::NUNITS-1:0] unit_io_en,
  output logic [7:0] pwr_ctl,
  output logic [ldc_pkg::NUNITS-1:0][15:0] io_base,
  output logic [ldc_pkg::NUNITS-1:0][15:0] io_base2,
  output logic [ldc_pkg::NUNITS-1:0][3:0] irq_sel,
  output logic [3:0] kbd_irq_sec,
  output logic irq_edge_high,
  output logic [ldc_pkg::NUNITS-1:0][2:0] dma_sel,
  output logic [ldc_pkg::NUNITS-1:0] dma_en
);
  import ldc_pkg::*;

  logic [7:0] index_q;
  logic [7:0] ldn_q;
  logic [7:0] rdata_q;
  logic rd_valid_q;
  logic [NUNITS-1:0] act_q;
  logic [NUNITS-1:0][15:0] base1_q;
  logic [NUNITS-1:0][15:0] base2_q;
  logic [NUNITS-1:0][3:0] irq0_q;
  logic [3:0] irq1_q;
  logic [NUNITS-1:0][2:0] dma_q;
  logic [NUNITS-1:0] unit_hit;
  logic [NUNITS-1:0] base_ok;
  logic [2:0] sel_unit;
  logic [7:0] rd_val;
  logic [7:0] pwr_val;

  // Access qualification
  wire idx_ok = index_wr && cfg_state;
  wire wr_ok = data_wr && cfg_state;
  wire rd_ok = data_rd && cfg_state;
  wire bank_ok = |unit_hit;
  wire bank_wr = wr_ok && bank_ok;
  wire wr_ldn = wr_ok && (index_q == IDX_LDN);
  wire wr_pwr = wr_ok && (index_q == IDX_PWR);
  wire wr_act = bank_wr && (index_q == IDX_ACT);
  wire wr_b1h = bank_wr && (index_q == IDX_BASE1_HI);
  wire wr_b1l = bank_wr && (index_q == IDX_BASE1_LO);
  wire wr_b2h = bank_wr && (index_q == IDX_BASE2_HI);
  wire wr_b2l = bank_wr && (index_q == IDX_BASE2_LO);
  wire wr_irq0 = bank_wr && (index_q == IDX_IRQ0);
  wire wr_irq1 = bank_wr && (index_q == IDX_IRQ1) && unit_hit[U_KBD];
  wire wr_dma = bank_wr && (index_q == IDX_DMA);

  // Index and unit number registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      index_q <= INDEX_RST;
    end
    else if (idx_ok)
    begin
      index_q <= wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ldn_q <= LDN_RST;
    end
    else if (wr_ldn)
    begin
      ldn_q <= wdata;
    end
  end

  // Bank selection; unknown unit numbers select nothing
  always_comb
  begin
    sel_unit = 3'h0;
    for (int k = 0; k < NUNITS; k++)
    begin
      if (unit_hit[k])
      begin
        sel_unit = 3'(k);
      end
    end
  end

  for (genvar i = 0; i < NUNITS; i++)
  begin : g_unit
    logic act_r;
    assign unit_hit[i] = (ldn_q == UNIT_LDN[i]);
    // Activate and power flag are one bit, so they always agree
    wire act_d = (wr_act && unit_hit[i]) ? wdata[ACT_BIT] :
                 (wr_pwr && HAS_PWR[i]) ? wdata[PWR_POS[i]] : act_q[i];
    // Own flop per unit: the two reset domains must not share one process target
    if (i == U_SER2)
    begin : g_stby
      // Survives bus reset; only the standby supply reset clears it
      always_ff @(posedge mclk or posedge stby_rst)
      begin
        if (stby_rst)
        begin
          act_r <= ACT_RST;
        end
        else
        begin
          act_r <= act_d;
        end
      end
    end
    else
    begin : g_main
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          act_r <= ACT_RST;
        end
        else
        begin
          act_r <= act_d;
        end
      end
    end
    assign act_q[i] = act_r;

    if (HAS_BASE1[i])
    begin : g_b1
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          base1_q[i] <= BASE_RST;
        end
        else if (wr_b1h && unit_hit[i])
        begin
          base1_q[i][15:8] <= wdata;
        end
        else if (wr_b1l && unit_hit[i])
        begin
          base1_q[i][7:0] <= wdata;
        end
      end
    end
    else
    begin : g_nb1
      assign base1_q[i] = BASE_RST;
    end

    if (HAS_BASE2[i])
    begin : g_b2
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          base2_q[i] <= BASE_RST;
        end
        else if (wr_b2h && unit_hit[i])
        begin
          base2_q[i][15:8] <= wdata;
        end
        else if (wr_b2l && unit_hit[i])
        begin
          base2_q[i][7:0] <= wdata;
        end
      end
    end
    else
    begin : g_nb2
      assign base2_q[i] = BASE_RST;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
      if (rst)
      begin
        irq0_q[i] <= IRQ_RST;
      end
      else if (wr_irq0 && unit_hit[i])
      begin
        irq0_q[i] <= wdata[3:0];
      end
    end

    if (HAS_DMA[i])
    begin : g_dma
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          dma_q[i] <= DMA_RST;
        end
        else if (wr_dma && unit_hit[i])
        begin
          dma_q[i] <= wdata[2:0];
        end
      end
    end
    else
    begin : g_ndma
      assign dma_q[i] = 3'h0;
    end

    ldc_base_check #(.UNIT(i)) u_chk
    (
      .base(base1_q[i]),
      .ok(base_ok[i])
    );
    assign unit_io_en[i] = act_q[i] && base_ok[i];
    assign dma_en[i] = HAS_DMA[i] && !dma_q[i][DMA_NONE_BIT];
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      irq1_q <= IRQ_RST;
    end
    else if (wr_irq1)
    begin
      irq1_q <= wdata[3:0];
    end
  end

  // Power control view of the linked flags
  always_comb
  begin
    pwr_val = 8'h00;
    for (int k = 0; k < NUNITS; k++)
    begin
      if (HAS_PWR[k])
      begin
        pwr_val[PWR_POS[k]] = act_q[k];
      end
    end
  end

  // Read decode; everything not listed reads zero
  always_comb
  begin
    rd_val = 8'h00;
    if (index_q == IDX_LDN)
    begin
      rd_val = ldn_q;
    end
    else if (index_q == IDX_PWR)
    begin
      rd_val = pwr_val;
    end
    else if (!bank_ok)
    begin
      rd_val = 8'h00;
    end
    else if (index_q == IDX_ACT)
    begin
      rd_val = {7'h00, act_q[sel_unit]};
    end
    else if (index_q == IDX_BASE1_HI)
    begin
      rd_val = base1_q[sel_unit][15:8];
    end
    else if (index_q == IDX_BASE1_LO)
    begin
      rd_val = base1_q[sel_unit][7:0];
    end
    else if (index_q == IDX_BASE2_HI)
    begin
      rd_val = base2_q[sel_unit][15:8];
    end
    else if (index_q == IDX_BASE2_LO)
    begin
      rd_val = base2_q[sel_unit][7:0];
    end
    else if (index_q == IDX_IRQ0)
    begin
      rd_val = {4'h0, irq0_q[sel_unit]};
    end
    else if ((index_q == IDX_IRQ1) && unit_hit[U_KBD])
    begin
      rd_val = {4'h0, irq1_q};
    end
    else if (index_q == IDX_DMA)
    begin
      rd_val = {5'h00, dma_q[sel_unit]};
    end
  end

  // Read data held until the next accepted read
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= rd_ok;
      if (rd_ok)
      begin
        rdata_q <= rd_val;
      end
    end
  end

  assign rdata = rdata_q;
  assign rd_valid = rd_valid_q;
  assign unit_active = act_q;
  assign pwr_ctl = pwr_val;
  assign io_base = base1_q;
  assign io_base2 = base2_q;
  assign irq_sel = irq0_q;
  assign kbd_irq_sec = irq1_q;
  // Legacy bus interrupts are never level or inverted here
  assign irq_edge_high = 1'b1;
  assign dma_sel = dma_q;

  AST_ACT_WRITE: assert property (@(posedge mclk) disable iff (rst || stby_rst)
    (wr_act) |=> (act_q[$past(sel_unit)] == $past(wdata[ACT_BIT])))
    else $error("activate write not stored");

  AST_NO_CFG: assert property (@(posedge mclk) disable iff (rst || stby_rst)
    (!cfg_state && data_wr) |=> ($stable(act_q) && $stable(ldn_q) && $stable(irq0_q)))
    else $error("write outside configuration state took effect");

  AST_NO_CFG_READ: assert property (@(posedge mclk) disable iff (rst)
    (!cfg_state) |=> !rd_valid)
    else $error("read answered outside configuration state");

  AST_RSV_ZERO: assert property (@(posedge mclk) disable iff (rst)
    (rd_ok && (index_q >= IDX_RSV_LO) && (index_q <= IDX_RSV_HI)) |=> (rd_valid && rdata == 8'h00))
    else $error("reserved index read nonzero");

  AST_UNIMP_ZERO: assert property (@(posedge mclk) disable iff (rst)
    (rd_ok && ((index_q == 8'h71) || (index_q == 8'h73) || (index_q >= 8'h76 && index_q <= 8'hDF)))
    |=> (rdata == 8'h00))
    else $error("unimplemented index read nonzero");

  AST_DMA75_ZERO: assert property (@(posedge mclk) disable iff (rst)
    (rd_ok && index_q == 8'h75) |=> (rdata == 8'h00))
    else $error("index 0x75 read nonzero");

  AST_BASE_HI: assert property (@(posedge mclk) disable iff (rst)
    (wr_b1h && HAS_BASE1[sel_unit]) |=> (io_base[$past(sel_unit)][15:8] == $past(wdata)))
    else $error("base high byte not stored");

  AST_IRQ2_KBD: assert property (@(posedge mclk) disable iff (rst)
    (rd_ok && index_q == IDX_IRQ1 && !unit_hit[U_KBD]) |=> (rdata == 8'h00))
    else $error("second interrupt select visible outside keyboard unit");

  AST_PWR_LINK: assert property (@(posedge mclk) disable iff (rst || stby_rst)
    (wr_pwr) |=> (act_q[U_FLOPPY] == $past(wdata[0]) && act_q[U_SER2] == $past(wdata[5])))
    else $error("power flags did not follow activate flags");

  AST_OTHER_BANK: assert property (@(posedge mclk) disable iff (rst)
    (wr_irq0 && !unit_hit[U_FLOPPY]) |=> $stable(irq0_q[U_FLOPPY]))
    else $error("write leaked into another unit bank");

  AST_IO_EN: assert property (@(posedge mclk) disable iff (rst)
    (unit_io_en[U_SER1]) |-> (act_q[U_SER1] && io_base[U_SER1][2:0] == 3'h0
      && io_base[U_SER1][11:0] >= BASE_MIN))
    else $error("serial 1 enabled with bad base");

  AST_DMA_NONE: assert property (@(posedge mclk) disable iff (rst)
    (dma_en[U_FLOPPY]) |-> (dma_sel[U_FLOPPY] <= 3'h3))
    else $error("DMA enabled with no-channel code");
endmodule : ldc_bank
`default_nettype wire

// [verilog/ldc_pkg.sv]
// Constants for the per-unit configuration register bank
`default_nettype none
package ldc_pkg;
  localparam int NUNITS = 7;
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_PWR = 8'h22;
  localparam logic [7:0] IDX_ACT = 8'h30;
  localparam logic [7:0] IDX_RSV_LO = 8'h31;
  localparam logic [7:0] IDX_RSV_HI = 8'h5F;
  localparam logic [7:0] IDX_BASE1_HI = 8'h60;
  localparam logic [7:0] IDX_BASE1_LO = 8'h61;
  localparam logic [7:0] IDX_BASE2_HI = 8'h62;
  localparam logic [7:0] IDX_BASE2_LO = 8'h63;
  localparam logic [7:0] IDX_IRQ0 = 8'h70;
  localparam logic [7:0] IDX_IRQ1 = 8'h72;
  localparam logic [7:0] IDX_DMA = 8'h74;
  localparam logic [7:0] LDN_RST = 8'h00;
  localparam logic [7:0] INDEX_RST = 8'h00;
  localparam logic ACT_RST = 1'b0;
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam logic [3:0] IRQ_RST = 4'h0;
  localparam logic [2:0] DMA_RST = 3'h4;
  localparam int ACT_BIT = 0;
  localparam int DMA_NONE_BIT = 2;
  // Unit slots
  localparam int U_FLOPPY = 0;
  localparam int U_PAR = 1;
  localparam int U_SER1 = 2;
  localparam int U_SER2 = 3;
  localparam int U_KBD = 4;
  localparam int U_AUX = 5;
  localparam int U_ACPI = 6;
  localparam logic [6:0][7:0] UNIT_LDN = {8'h0A, 8'h08, 8'h07, 8'h05, 8'h04, 8'h03, 8'h00};
  localparam logic [6:0] HAS_BASE1 = 7'h4F;
  localparam logic [6:0] HAS_BASE2 = 7'h40;
  localparam logic [6:0] HAS_DMA = 7'h0B;
  localparam logic [6:0] HAS_PWR = 7'h0F;
  localparam logic [6:0][2:0] PWR_POS = {3'h0, 3'h0, 3'h0, 3'h5, 3'h4, 3'h3, 3'h0};
  // Base decode ranges on address bits 11:0
  localparam logic [11:0] BASE_MIN = 12'h100;
  localparam logic [11:0] BASE_MAX8 = 12'hFF8;
  localparam logic [11:0] BASE_MAX4 = 12'hFFC;
  localparam logic [11:0] ACPI_MAX = 12'hFE7;
  localparam logic [11:0] ACPI_ALIGN = 12'h018;
  typedef enum logic [1:0] {
    RANGE_ALIGN8 = 2'b00,
    RANGE_ALIGN4 = 2'b01,
    RANGE_ACPI = 2'b10,
    RANGE_FIXED = 2'b11
  } ldc_range_type;
  localparam ldc_range_type UNIT_RANGE [NUNITS] = '{RANGE_ALIGN8, RANGE_ALIGN4, RANGE_ALIGN8,
    RANGE_ALIGN8, RANGE_FIXED, RANGE_FIXED, RANGE_ACPI};
endpackage : ldc_pkg
`default_nettype wire

// [verilog/ldc_base_check.sv]
// Permitted I/O base range check for one unit
`timescale 1ns/1ps
`default_nettype none
module ldc_base_check
  import ldc_pkg::*;
#(
  parameter int UNIT = 0
)
(
  // Programmed base
  input wire logic [15:0] base,
  // Result
  output logic ok
);
  localparam ldc_range_type KIND = UNIT_RANGE[UNIT];
  wire [11:0] addr = base[11:0];
  wire [11:0] acpi_rem = addr % ACPI_ALIGN;
  wire in8 = (addr >= BASE_MIN) && (addr <= BASE_MAX8) && (addr[2:0] == 3'h0);
  wire in4 = (addr >= BASE_MIN) && (addr <= BASE_MAX4) && (addr[1:0] == 2'h0);
  wire in_acpi = (addr <= ACPI_MAX) && (acpi_rem == 12'h000);
  // Fixed-address units have nothing to misprogram
  assign ok = (KIND == RANGE_FIXED) ? 1'b1 :
              (KIND == RANGE_ALIGN4) ? in4 :
              (KIND == RANGE_ACPI) ? in_acpi : in8;
endmodule : ldc_base_check
`default_nettype wire

// [test/ldc_host_model.sv]
// Host model driving the index and data configuration ports
`timescale 1ns/1ps
`default_nettype none
module ldc_host_model
(
  // Clock
  input wire logic mclk,
  // Port strobes
  output logic cfg_state,
  output logic index_wr,
  output logic data_wr,
  output logic data_rd,
  output logic [7:0] wdata,
  // Read answer
  input wire logic [7:0] rdata,
  input wire logic rd_valid
);
  initial
  begin
    cfg_state = 1'b1;
    index_wr = 1'b0;
    data_wr = 1'b0;
    data_rd = 1'b0;
    wdata = 8'hA5;
  end

  task automatic set_cfg(input logic on);
    @(posedge mclk);
    cfg_state <= on;
  endtask : set_cfg

  // Index write, then data strobe one cycle later
  task automatic put(input logic [7:0] idx, input logic [7:0] val);
    @(posedge mclk);
    index_wr <= 1'b1;
    wdata <= idx;
    @(posedge mclk);
    index_wr <= 1'b0;
    data_wr <= 1'b1;
    wdata <= val;
    @(posedge mclk);
    data_wr <= 1'b0;
    // Released bus must not keep showing the last byte
    wdata <= ~val;
  endtask : put

  task automatic get(input logic [7:0] idx, output logic [7:0] val, output logic seen);
    @(posedge mclk);
    index_wr <= 1'b1;
    wdata <= idx;
    @(posedge mclk);
    index_wr <= 1'b0;
    data_rd <= 1'b1;
    wdata <= ~idx;
    @(posedge mclk);
    data_rd <= 1'b0;
    seen = 1'b0;
    val = 8'h00;
    for (int i = 0; i < 3 && !seen; i++)
    begin
      #1;
      if (rd_valid === 1'b1)
      begin
        seen = 1'b1;
        val = rdata;
      end
      else
        @(posedge mclk);
    end
  endtask : get
endmodule : ldc_host_model
`default_nettype wire

// [test/logical_device_config_bank_test.sv]
// Self-checking bench for the per-unit configuration bank
`timescale 1ns/1ps
`default_nettype none
module logical_device_config_bank_test;
  import ldc_pkg::*;
  logic mclk;
  logic rst;
  logic stby_rst;
  wire logic cfg_state;
  wire logic index_wr;
  wire logic data_wr;
  wire logic data_rd;
  wire logic [7:0] wdata;
  logic [7:0] rdata;
  logic rd_valid;
  logic [NUNITS-1:0] unit_active;
  logic [NUNITS-1:0] unit_io_en;
  logic [7:0] pwr_ctl;
  logic [NUNITS-1:0][15:0] io_base;
  logic [NUNITS-1:0][15:0] io_base2;
  logic [NUNITS-1:0][3:0] irq_sel;
  logic [3:0] kbd_irq_sec;
  logic irq_edge_high;
  logic [NUNITS-1:0][2:0] dma_sel;
  logic [NUNITS-1:0] dma_en;
  int err_count;
  int compares;
  logic [7:0] v;
  logic s;
  localparam logic [7:0] WIDX [8] = '{8'h30, 8'h60, 8'h61, 8'h62, 8'h63, 8'h70, 8'h72, 8'h74};
  localparam logic [7:0] RSV [13] = '{8'h31, 8'h37, 8'h38, 8'h3F, 8'h40, 8'h5F, 8'h71,
    8'h73, 8'h75, 8'h76, 8'hA8, 8'hA9, 8'hDF};

  ldc_host_model host (.mclk(mclk), .cfg_state(cfg_state), .index_wr(index_wr),
    .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid));

  ldc_bank dut (.mclk(mclk), .rst(rst), .stby_rst(stby_rst), .cfg_state(cfg_state),
    .index_wr(index_wr), .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata),
    .rdata(rdata), .rd_valid(rd_valid), .unit_active(unit_active), .unit_io_en(unit_io_en),
    .pwr_ctl(pwr_ctl), .io_base(io_base), .io_base2(io_base2), .irq_sel(irq_sel),
    .kbd_irq_sec(kbd_irq_sec), .irq_edge_high(irq_edge_high), .dma_sel(dma_sel),
    .dma_en(dma_en));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] val;
    logic seen;
    host.get(idx, val, seen);
    chk("rd_valid", 16'h0001, 16'(seen));
    chk($sformatf("index %h", idx), 16'(exp), 16'(val));
  endtask : rd

  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    host.put(idx, val);
    #1;
  endtask : wr

  task automatic sel(input int u);
    wr(IDX_LDN, UNIT_LDN[u]);
  endtask : sel

  // First bases stay 24-aligned so the ACPI slot is also in range
  function automatic logic [7:0] wval(input int u, input int k);
    case (k)
      0: return 8'h01;
      1: return 8'(3 * (u % 4 + 1));
      2: return 8'h30;
      3: return 8'h0A;
      4: return 8'h18;
      5: return 8'(u + 1);
      6: return 8'h0B;
      default: return 8'(u % 4);
    endcase
  endfunction : wval

  function automatic logic has(input int u, input int k);
    case (k)
      1, 2: return HAS_BASE1[u];
      3, 4: return HAS_BASE2[u];
      6: return u == U_KBD;
      7: return HAS_DMA[u];
      default: return 1'b1;
    endcase
  endfunction : has

  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  initial
  begin
    #100000;
    err_count++;
    complete_run();
  end

  initial
  begin
    err_count = 0;
    compares = 0;
    rst = 1'b1;
    stby_rst = 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    stby_rst <= 1'b0;
    for (int u = 0; u < NUNITS; u++)
    begin
      sel(u);
      for (int k = 0; k < 8; k++)
        rd(WIDX[k], (k == 7 && HAS_DMA[u]) ? 8'h04 : 8'h00);
    end
    chk("irq_edge_high", 16'h0001, 16'(irq_edge_high));
    chk("dma_en", 16'h0000, 16'(dma_en));
    for (int u = 0; u < NUNITS; u++)
    begin
      sel(u);
      for (int k = 0; k < 8; k++)
        wr(WIDX[k], wval(u, k));
    end
    for (int u = 0; u < NUNITS; u++)
    begin
      sel(u);
      for (int k = 0; k < 8; k++)
        rd(WIDX[k], has(u, k) ? wval(u, k) : 8'h00);
      chk("irq_sel", 16'(u + 1), 16'(irq_sel[u]));
    end
    chk("unit_active", 16'h007F, 16'(unit_active));
    chk("pwr_ctl", 16'h0039, 16'(pwr_ctl));
    chk("unit_io_en", 16'h007F, 16'(unit_io_en));
    chk("dma_en", 16'(HAS_DMA), 16'(dma_en));
    chk("kbd_irq_sec", 16'h000B, 16'(kbd_irq_sec));
    chk("io_base", 16'h0930, io_base[U_ACPI]);
    chk("io_base2", 16'h0A18, io_base2[U_ACPI]);
    chk("io_base2 unused", 16'h0000, io_base2[U_SER1]);
    for (int u = 0; u < NUNITS; u++)
    begin
      sel(u);
      for (int r = 0; r < 13; r++)
      begin
        wr(RSV[r], 8'hFF);
        rd(RSV[r], 8'h00);
      end
    end
    sel(U_FLOPPY);
    host.set_cfg(1'b0);
    wr(IDX_IRQ0, 8'h0F);
    host.get(IDX_IRQ0, v, s);
    chk("rd_valid refused", 16'h0000, 16'(s));
    host.set_cfg(1'b1);
    rd(IDX_IRQ0, 8'h01);
    wr(IDX_PWR, 8'h30);
    chk("unit_active", 16'h007C, 16'(unit_active));
    rd(IDX_ACT, 8'h00);
    wr(IDX_ACT, 8'h01);
    chk("pwr_ctl", 16'h0031, 16'(pwr_ctl));
    wr(IDX_BASE1_LO, 8'h34);
    chk("io_en misaligned", 16'h0000, 16'(unit_io_en[U_FLOPPY]));
    wr(IDX_BASE1_LO, 8'h30);
    wr(IDX_BASE1_HI, 8'h00);
    chk("io_en low", 16'h0000, 16'(unit_io_en[U_FLOPPY]));
    wr(IDX_BASE1_HI, 8'h03);
    chk("io_en ok", 16'h0001, 16'(unit_io_en[U_FLOPPY]));
    chk("io_base", 16'h0330, io_base[U_FLOPPY]);
    for (int c = 0; c < 8; c++)
    begin
      wr(IDX_DMA, 8'(c));
      chk("dma_sel", 16'(c), 16'(dma_sel[U_FLOPPY]));
      chk("dma_en", 16'(c < 4), 16'(dma_en[U_FLOPPY]));
    end
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk("unit_active", 16'h0008, 16'(unit_active));
    chk("pwr_ctl", 16'h0020, 16'(pwr_ctl));
    chk("irq_sel", 16'h0000, 16'(irq_sel));
    chk("kbd_irq_sec", 16'h0000, 16'(kbd_irq_sec));
    chk("dma_sel reset", 16'h0004, 16'(dma_sel[U_FLOPPY]));
    chk("io_base reset", 16'h0000, io_base[U_FLOPPY]);
    @(posedge mclk);
    stby_rst <= 1'b1;
    @(posedge mclk);
    stby_rst <= 1'b0;
    #1;
    chk("unit_active", 16'h0000, 16'(unit_active));
    complete_run();
  end
endmodule : logical_device_config_bank_test
`default_nettype wire
